// ==== hdl/aacr_consts.svh ====
// Offsets, field positions and reset values of the configuration bank
`ifndef AACR_CONSTS_SVH
`define AACR_CONSTS_SVH
// ****************************************
// Register indices and address width
// ****************************************
`define AACR_IDX_TAGS      8'h1C
`define AACR_IDX_CALKEY    8'h33
`define AACR_IDX_TLOAD     8'h90
`define AACR_IDX_TRESULT   8'h91
`define AACR_IDX_CLKAVG    8'hC0
`define AACR_ADDR_W        10
// ****************************************
// Field positions
// ****************************************
`define AACR_TAG_UPPER_HI  15
`define AACR_TAG_UPPER_LO  8
`define AACR_TAG_LOWER_HI  7
`define AACR_TAG_LOWER_LO  0
`define AACR_GAIN_UPPER    13
`define AACR_GAIN_LOWER    6
`define AACR_KEY_HI        5
`define AACR_KEY_LO        4
`define AACR_CAPTURE_BIT   14
`define AACR_TEMP_HI       9
`define AACR_LANE_CLK_BIT  12
`define AACR_AVG_HI        11
`define AACR_AVG_LO        10
`define AACR_AVGCLK_HI     9
`define AACR_AVGCLK_LO     7
`define AACR_SLEEP_HI      1
`define AACR_SLEEP_LO      0
// ****************************************
// Values
// ****************************************
`define AACR_KEY_OPEN      2'h3
`define AACR_RESET_VAL     16'h0000
`endif

// ==== hdl/aacr_pkg.sv ====
// Types of the configuration bank
package aacr_pkg;
  typedef enum logic [1:0] {
    SLEEP_NONE,
    SLEEP_FIRST,
    SLEEP_SECOND,
    SLEEP_BOTH
  } aacr_sleep_type;
  typedef struct packed {
    logic [7:0]     tagLower;
    logic [7:0]     tagUpper;
    logic           gainCorrectionOnUpper;
    logic           gainCorrectionOnLower;
    logic           initAccessOpen;
    logic           laneClockSelectA;
    logic [1:0]     averagingSetupA;
    logic [2:0]     averagingOutputClockCfg;
    aacr_sleep_type channelSleepSelect;
  } aacr_cfg_type;
  typedef struct packed {
    logic [15:0] word;
    logic        valid;
  } aacr_conv_type;
endpackage

// ==== hdl/aacr_tag_append.sv ====
// Appends a user tag byte to one channel's conversion word
`timescale 1ns/1ps
`default_nettype none
module aacr_tag_append #(
  parameter int DATA_W = 16,
  parameter int TAG_W  = 8
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rstn,
  // Conversion in
  input  wire logic [DATA_W-1:0]   convWord,
  input  wire logic                convValid,
  input  wire logic [TAG_W-1:0]    tag,
  // Tagged out
  output logic [DATA_W+TAG_W-1:0]  taggedWord,
  output logic                     taggedValid
);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      taggedWord <= '0;
    end else if (convValid) begin
      taggedWord <= {convWord, tag};
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      taggedValid <= 1'b0;
    end else begin
      taggedValid <= convValid;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/aacr_regs.sv ====
// Configuration register bank with APB slave, tagging and temperature capture
`timescale 1ns/1ps
`default_nettype none
`include "aacr_consts.svh"
module aacr_regs #(
  parameter int DATA_W = 16,
  parameter int TAG_W  = 8,
  parameter int TEMP_W = 10
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rstn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Converter words
  input  wire aacr_pkg::aacr_conv_type  convFirst,
  input  wire aacr_pkg::aacr_conv_type  convSecond,
  output logic [DATA_W+TAG_W-1:0]       taggedFirst,
  output logic                          taggedFirstValid,
  output logic [DATA_W+TAG_W-1:0]       taggedSecond,
  output logic                          taggedSecondValid,
  // Temperature sensor
  input  wire logic [TEMP_W-1:0]        thermalLive,
  // Configuration out
  output aacr_pkg::aacr_cfg_type        cfg,
  output logic                          gainCorrectionActive,
  output logic                          firstPoweredDown,
  output logic                          secondPoweredDown
);
  // ****************************************
  // Bus decode
  // ****************************************
  logic [15:0] tags_q;
  logic [15:0] calKey_q;
  logic [15:0] tLoad_q;
  logic [15:0] tResult_q;
  logic [15:0] clkAvg_q;
  logic [7:0]  index;
  logic        aligned;
  logic        hitTags;
  logic        hitCalKey;
  logic        hitTLoad;
  logic        hitTResult;
  logic        hitClkAvg;
  logic        hitAny;
  logic        wrEn;
  logic [15:0] wMask;
  logic        captureBit;
  logic        capture_q;
  logic        startLoad;

  // Index times four is the byte address; upper address bits must be zero
  assign index      = paddr[9:2];
  assign aligned    = (paddr[1:0] == 2'h0) && (paddr[31:`AACR_ADDR_W] == '0);
  assign hitTags    = aligned && (index == `AACR_IDX_TAGS);
  assign hitCalKey  = aligned && (index == `AACR_IDX_CALKEY);
  assign hitTLoad   = aligned && (index == `AACR_IDX_TLOAD);
  assign hitTResult = aligned && (index == `AACR_IDX_TRESULT);
  assign hitClkAvg  = aligned && (index == `AACR_IDX_CLKAVG);
  assign hitAny     = hitTags || hitCalKey || hitTLoad || hitTResult || hitClkAvg;
  // Zero wait states
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !hitAny;
  assign wrEn       = psel && penable && pwrite && hitAny;
  assign wMask      = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [15:0] msk);
    merge = (old & ~msk) | (wd[15:0] & msk);
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  // Reserved bits are stored as written; software keeps them zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tags_q <= `AACR_RESET_VAL;
    end else if (wrEn && hitTags) begin
      tags_q <= merge(tags_q, pwdata, wMask);
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      calKey_q <= `AACR_RESET_VAL;
    end else if (wrEn && hitCalKey) begin
      calKey_q <= merge(calKey_q, pwdata, wMask);
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tLoad_q <= `AACR_RESET_VAL;
    end else if (wrEn && hitTLoad) begin
      tLoad_q <= merge(tLoad_q, pwdata, wMask);
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clkAvg_q <= `AACR_RESET_VAL;
    end else if (wrEn && hitClkAvg) begin
      clkAvg_q <= merge(clkAvg_q, pwdata, wMask);
    end
  end

  // ****************************************
  // Temperature capture
  // ****************************************
  assign captureBit = tLoad_q[`AACR_CAPTURE_BIT];
  // Edge of the stored bit, so a rewrite of 1 over 1 does nothing
  assign startLoad  = captureBit && !capture_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= captureBit;
    end
  end
  // Capture beats a software write in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tResult_q <= `AACR_RESET_VAL;
    end else if (startLoad) begin
      tResult_q <= {{(16-TEMP_W){1'b0}}, thermalLive};
    end else if (wrEn && hitTResult) begin
      tResult_q <= merge(tResult_q, pwdata, wMask) &
                   {{(16-TEMP_W){1'b0}}, {TEMP_W{1'b1}}};
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (hitTags) begin
        prdata[15:0] <= tags_q;
      end
      if (hitCalKey) begin
        prdata[15:0] <= calKey_q;
      end
      if (hitTLoad) begin
        prdata[15:0] <= tLoad_q;
      end
      if (hitTResult) begin
        prdata[15:0] <= tResult_q;
      end
      if (hitClkAvg) begin
        prdata[15:0] <= clkAvg_q;
      end
    end
  end

  // ****************************************
  // Configuration decode
  // ****************************************
  always_comb begin
    cfg.tagUpper              = tags_q[`AACR_TAG_UPPER_HI:`AACR_TAG_UPPER_LO];
    cfg.tagLower              = tags_q[`AACR_TAG_LOWER_HI:`AACR_TAG_LOWER_LO];
    cfg.gainCorrectionOnUpper = calKey_q[`AACR_GAIN_UPPER];
    cfg.gainCorrectionOnLower = calKey_q[`AACR_GAIN_LOWER];
    // Only the full key opens access; other codes stay normal
    cfg.initAccessOpen        = calKey_q[`AACR_KEY_HI:`AACR_KEY_LO] == `AACR_KEY_OPEN;
    cfg.laneClockSelectA      = clkAvg_q[`AACR_LANE_CLK_BIT];
    cfg.averagingSetupA       = clkAvg_q[`AACR_AVG_HI:`AACR_AVG_LO];
    cfg.averagingOutputClockCfg = clkAvg_q[`AACR_AVGCLK_HI:`AACR_AVGCLK_LO];
    cfg.channelSleepSelect    =
      aacr_pkg::aacr_sleep_type'(clkAvg_q[`AACR_SLEEP_HI:`AACR_SLEEP_LO]);
  end
  assign gainCorrectionActive = cfg.gainCorrectionOnUpper || cfg.gainCorrectionOnLower;

  always_comb begin
    case (cfg.channelSleepSelect)
      aacr_pkg::SLEEP_NONE: begin
        firstPoweredDown  = 1'b0;
        secondPoweredDown = 1'b0;
      end
      aacr_pkg::SLEEP_FIRST: begin
        firstPoweredDown  = 1'b1;
        secondPoweredDown = 1'b0;
      end
      aacr_pkg::SLEEP_SECOND: begin
        firstPoweredDown  = 1'b0;
        secondPoweredDown = 1'b1;
      end
      default: begin
        firstPoweredDown  = 1'b1;
        secondPoweredDown = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Tag appending
  // ****************************************
  aacr_tag_append #(.DATA_W(DATA_W), .TAG_W(TAG_W)) tagFirst (
    .clock       (clock),
    .rstn        (rstn),
    .convWord    (convFirst.word),
    .convValid   (convFirst.valid),
    .tag         (cfg.tagLower),
    .taggedWord  (taggedFirst),
    .taggedValid (taggedFirstValid)
  );
  aacr_tag_append #(.DATA_W(DATA_W), .TAG_W(TAG_W)) tagSecond (
    .clock       (clock),
    .rstn        (rstn),
    .convWord    (convSecond.word),
    .convValid   (convSecond.valid),
    .tag         (cfg.tagUpper),
    .taggedWord  (taggedSecond),
    .taggedValid (taggedSecondValid)
  );
endmodule
`default_nettype wire

// ==== bench/aacr_regs_props.sv ====
// Concurrent checks on the configuration bank ports
`timescale 1ns/1ps
`default_nettype none
module aacr_regs_props (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    rstn,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  // Converter words
  input wire aacr_pkg::aacr_conv_type convFirst,
  input wire aacr_pkg::aacr_conv_type convSecond,
  input wire logic [23:0]             taggedFirst,
  input wire logic                    taggedFirstValid,
  input wire logic [23:0]             taggedSecond,
  input wire logic                    taggedSecondValid,
  // Configuration
  input wire aacr_pkg::aacr_cfg_type  cfg,
  input wire logic                    gainCorrectionActive,
  input wire logic                    firstPoweredDown,
  input wire logic                    secondPoweredDown
);
  // ****************************************
  // Helpers
  // ****************************************
  logic acc, wrCal, wrClk, mapped;
  assign acc = psel && penable;
  assign wrCal = acc && pwrite && paddr == 32'h0CC && pstrb[1:0] == 2'h3;
  assign wrClk = acc && pwrite && paddr == 32'h300 && pstrb[1:0] == 2'h3;
  assign mapped = paddr inside {32'h070, 32'h0CC, 32'h240, 32'h244, 32'h300};
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ****************************************
  // Properties
  // ****************************************
  a_tag_first: assert property (convFirst.valid |=> taggedFirstValid &&
    taggedFirst == {$past(convFirst.word), $past(cfg.tagLower)})
    else $error("first channel tagged word wrong");
  a_tag_second: assert property (convSecond.valid |=> taggedSecondValid &&
    taggedSecond == {$past(convSecond.word), $past(cfg.tagUpper)})
    else $error("second channel tagged word wrong");
  a_gain_bits: assert property (wrCal |=> cfg.gainCorrectionOnUpper == $past(pwdata[13]) &&
    cfg.gainCorrectionOnLower == $past(pwdata[6]) &&
    gainCorrectionActive == ($past(pwdata[13]) || $past(pwdata[6])))
    else $error("gain correction enables wrong");
  a_key_open: assert property (wrCal |=> cfg.initAccessOpen == ($past(pwdata[5:4]) == 2'h3))
    else $error("init access decode wrong");
  a_sleep_decode: assert property (wrClk |=> firstPoweredDown == $past(pwdata[0]) &&
    secondPoweredDown == $past(pwdata[1]) && cfg.channelSleepSelect == $past(pwdata[1:0]))
    else $error("sleep decode wrong");
  a_clock_fields: assert property (wrClk |=> cfg.laneClockSelectA == $past(pwdata[12]) &&
    cfg.averagingSetupA == $past(pwdata[11:10]) &&
    cfg.averagingOutputClockCfg == $past(pwdata[9:7]))
    else $error("clock and averaging fields wrong");
  a_temp_upper: assert property (psel && !penable && !pwrite && paddr == 32'h244 |=>
    prdata[31:10] == 22'h0)
    else $error("temperature upper bits not zero");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
endmodule
`default_nettype wire

// ==== bench/aacr_regs_tb.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module aacr_regs_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic                    clock, rstn, psel, penable, pwrite;
  logic [31:0]             paddr, pwdata, prdata;
  logic [3:0]              pstrb;
  logic                    pready, pslverr, tfv, tsv;
  aacr_pkg::aacr_conv_type convFirst, convSecond;
  logic [23:0]             taggedFirst, taggedSecond;
  logic [9:0]              thermalLive, t1, t2;
  aacr_pkg::aacr_cfg_type  cfg;
  logic [15:0]             tag, v;
  int                      numErrors = 0;
  int                      checksDone = 0;
  logic [31:0]             rdq[$];
  logic [23:0]             tgq[$];
  logic [23:0]             tsq[$];
  logic [31:0]             addrs[5] = '{32'h070, 32'h0CC, 32'h240, 32'h244, 32'h300};
  always #12.5 clock = ~clock;
  aacr_regs dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convFirst(convFirst), .convSecond(convSecond),
    .taggedFirst(taggedFirst), .taggedFirstValid(tfv), .taggedSecond(taggedSecond),
    .taggedSecondValid(tsv), .thermalLive(thermalLive), .cfg(cfg),
    .gainCorrectionActive(), .firstPoweredDown(), .secondPoweredDown());
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrapUp;
    if (numErrors == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      $display("BAD prdata exp %h got %h", e, g);
      numErrors++;
    end
  endtask
  task automatic cmp_tag(input string nm, input logic [23:0] e, input logic [23:0] g);
    checksDone++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      numErrors++;
    end
  endtask
  // Waits are bounded; a hung slave ends the run
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rdq.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      numErrors++;
      wrapUp;
    end else begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  // ****************************************
  // Monitor
  // ****************************************
  always @(posedge clock) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      cmp_rd(rdq.size() > 0 ? rdq.pop_front() : 32'hX, prdata);
    end
    if (tfv === 1'b1) begin
      cmp_tag("taggedFirst", tgq.size() > 0 ? tgq.pop_front() : 24'hX, taggedFirst);
    end
    if (tsv === 1'b1) begin
      cmp_tag("taggedSecond", tsq.size() > 0 ? tsq.pop_front() : 24'hX, taggedSecond);
    end
  end
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    convFirst = '0;
    convSecond = '0;
    thermalLive = 10'h0;
    void'($urandom(72400));
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    foreach (addrs[i]) rd(addrs[i], 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom) & 16'h2040 | 16'(i) << 4;
      wr(32'h0CC, {16'h0, v});
      rd(32'h0CC, {16'h0, v});
      // Averaging field kept to its two defined codes
      v = 16'($urandom) & 16'h1780 | 16'(i);
      wr(32'h300, {16'h0, v});
      rd(32'h300, {16'h0, v});
    end
    // Unmapped place reads as zero
    wr(32'h104, 32'hFFFF);
    rd(32'h104, 32'h0);
    wr(32'h244, 32'h03FF);
    rd(32'h244, 32'h3FF);
    t1 = 10'($urandom);
    t2 = t1 ^ 10'h155;
    thermalLive <= t1;
    wr(32'h240, 32'h4000);
    rd(32'h244, {22'h0, t1});
    thermalLive <= t2;
    wr(32'h240, 32'h4000);
    rd(32'h244, {22'h0, t1});
    wr(32'h240, 32'h0);
    rd(32'h244, {22'h0, t1});
    wr(32'h240, 32'h4000);
    rd(32'h244, {22'h0, t2});
    tag = 16'($urandom);
    wr(32'h070, {16'h0, tag});
    rd(32'h070, {16'h0, tag});
    for (int j = 0; j < 6; j++) begin
      v = 16'($urandom);
      convFirst.word <= v;
      convFirst.valid <= (j != 3);
      convSecond.word <= ~v;
      convSecond.valid <= 1'b1;
      if (j != 3) tgq.push_back({v, tag[7:0]});
      tsq.push_back({~v, tag[15:8]});
      @(posedge clock);
    end
    convFirst.valid <= 1'b0;
    convSecond.valid <= 1'b0;
    repeat (3) @(posedge clock);
    if (tgq.size() != 0 || tsq.size() != 0) numErrors++;
    wrapUp;
  end
endmodule
bind aacr_regs aacr_regs_props u_props (.clock(clock), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr), .convFirst(convFirst), .convSecond(convSecond),
  .taggedFirst(taggedFirst), .taggedFirstValid(taggedFirstValid),
  .taggedSecond(taggedSecond), .taggedSecondValid(taggedSecondValid), .cfg(cfg),
  .gainCorrectionActive(gainCorrectionActive), .firstPoweredDown(firstPoweredDown),
  .secondPoweredDown(secondPoweredDown));
`default_nettype wire
